/* File: logic/mer_exception_responder.sv */
`timescale 1ns/1ps
module mer_exception_responder #(
   parameter int DATA_W = 8
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Parsed query from the frame receiver.
   input wire logic i_qry_valid,
   output logic o_qry_ready,
   input wire logic [7:0] i_qry_addr,
   input wire logic [7:0] i_qry_func,
   input wire logic i_qry_bcast,
   input wire logic [15:0] i_qry_rd_cnt,
   input wire logic [15:0] i_qry_wr_cnt,
   input wire logic [7:0] i_qry_byte_cnt,
   // Check results from the register map, valid with the query.
   input wire logic i_chk_no_addr,
   input wire logic i_chk_bad_format,
   input wire logic i_chk_out_of_range,
   input wire logic i_chk_run_locked,
   input wire logic i_chk_soft_locked,
   input wire logic i_chk_fixed_pin,
   input wire logic i_chk_reset_terminal_function,
   input wire logic i_chk_pw_locked,
   input wire logic i_chk_read_only,
   input wire logic i_chk_upper_word,
   input wire logic i_chk_map_err1,
   input wire logic i_chk_map_err2,
   // Drive status levels.
   input wire logic i_autotune_on,
   input wire logic i_nv_busy,
   // Request to the normal reply builder.
   output logic o_normal_req,
   output logic [7:0] o_exc_code,
   // Exception byte stream toward the transmitter.
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   output logic [DATA_W-1:0] o_tx_data,
   output logic o_tx_last
);

   // Folds one byte into a running CRC-16.
   function automatic logic [15:0] crc_upd(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         if (c[0]) begin
            c = (c >> 1) ^ mer_pkg::CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   // A register count of zero or above the limit is refused.
   function automatic logic cnt_bad(input logic [15:0] c);
      return (c == mer_pkg::WORD_RST) || (c > mer_pkg::MAX_REGS);
   endfunction

   mer_pkg::mer_state_t state_r;
   logic take;
   logic supported;
   logic is_write;
   logic cnt_err;
   logic any_err;
   logic [7:0] cause_nxt;
   logic [7:0] addr_r;
   logic [7:0] func_r;
   logic [7:0] cause_r;
   logic [15:0] crc_r;
   logic [15:0] crc_nxt;
   logic [2:0] idx_r;
   logic push;
   logic [DATA_W-1:0] push_data;
   logic push_last;
   logic buf_in_ready;
   logic pop;
   logic [DATA_W-1:0] spare_data_r;
   logic spare_last_r;
   logic spare_valid_r;

   assign take = i_qry_valid && o_qry_ready;

   // Classify the function code and check the register counts.
   always_comb begin
      supported = 1'b0;
      is_write = 1'b0;
      cnt_err = 1'b0;
      unique case (i_qry_func)
         mer_pkg::FN_READ_COILS: supported = 1'b1;
         mer_pkg::FN_READ_REGS: begin
            supported = 1'b1;
            cnt_err = cnt_bad(i_qry_rd_cnt);
         end
         mer_pkg::FN_WRITE_COIL, mer_pkg::FN_WRITE_REG, mer_pkg::FN_WRITE_COILS: begin
            supported = 1'b1;
            is_write = 1'b1;
         end
         mer_pkg::FN_WRITE_REGS: begin
            supported = 1'b1;
            is_write = 1'b1;
            cnt_err = cnt_bad(i_qry_wr_cnt) ||
                      ({i_qry_wr_cnt[14:0], 1'b0} != {8'h00, i_qry_byte_cnt});
         end
         mer_pkg::FN_RW_REGS: begin
            supported = 1'b1;
            is_write = 1'b1;
            cnt_err = cnt_bad(i_qry_rd_cnt) || cnt_bad(i_qry_wr_cnt) ||
                      ({i_qry_wr_cnt[14:0], 1'b0} != {8'h00, i_qry_byte_cnt});
         end
         default: supported = 1'b0;
      endcase
   end

   // Pick one cause; structural faults outrank state-dependent refusals.
   // A lower-word-only access raises no flag and so passes through untouched.
   always_comb begin
      any_err = 1'b1;
      cause_nxt = mer_pkg::BYTE_RST;
      if (!supported) begin
         cause_nxt = mer_pkg::EXC_BAD_FUNC;
      end else if (i_chk_no_addr) begin
         cause_nxt = mer_pkg::EXC_BAD_ADDR;
      end else if (i_chk_bad_format || cnt_err) begin
         cause_nxt = mer_pkg::EXC_BAD_FORMAT;
      end else if (i_chk_upper_word) begin
         cause_nxt = mer_pkg::EXC_UPPER_WORD;
      end else if (is_write && i_chk_read_only) begin
         cause_nxt = mer_pkg::EXC_READ_ONLY;
      end else if (is_write && i_nv_busy) begin
         cause_nxt = mer_pkg::EXC_NV_BUSY;
      end else if (i_chk_run_locked || i_chk_soft_locked || i_chk_fixed_pin) begin
         cause_nxt = mer_pkg::EXC_REFUSED;
      end else if ((is_write && i_autotune_on) || i_chk_pw_locked) begin
         cause_nxt = mer_pkg::EXC_REFUSED;
      end else if (i_chk_reset_terminal_function) begin
         cause_nxt = mer_pkg::EXC_REFUSED;
      end else if (is_write && i_chk_out_of_range) begin
         cause_nxt = mer_pkg::EXC_OUT_OF_RANGE;
      end else if (i_chk_map_err1) begin
         cause_nxt = mer_pkg::EXC_MAP_ERR1;
      end else if (i_chk_map_err2) begin
         cause_nxt = mer_pkg::EXC_MAP_ERR2;
      end else begin
         any_err = 1'b0;
      end
   end

   // The CRC is worked out once at capture so the send loop stays a plain mux.
   always_comb begin
      crc_nxt = crc_upd(mer_pkg::CRC_INIT, i_qry_addr);
      crc_nxt = crc_upd(crc_nxt, i_qry_func | mer_pkg::EXC_FN_FLAG);
      crc_nxt = crc_upd(crc_nxt, cause_nxt);
   end

   // Controller: a broadcast is swallowed, a clean query goes to the normal builder.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r <= mer_pkg::ST_IDLE;
         o_qry_ready <= 1'b0;
         o_normal_req <= 1'b0;
         idx_r <= mer_pkg::IDX_ADDR;
      end else begin
         o_normal_req <= 1'b0;
         unique case (state_r)
            mer_pkg::ST_IDLE: begin
               o_qry_ready <= 1'b1;
               idx_r <= mer_pkg::IDX_ADDR;
               if (take && !i_qry_bcast) begin
                  if (any_err) begin
                     state_r <= mer_pkg::ST_SEND;
                     o_qry_ready <= 1'b0;
                  end else begin
                     o_normal_req <= 1'b1;
                  end
               end
            end
            mer_pkg::ST_SEND: begin
               if (push) begin
                  if (idx_r == mer_pkg::IDX_CRC_HI) begin
                     state_r <= mer_pkg::ST_IDLE;
                     o_qry_ready <= 1'b1;
                  end else begin
                     idx_r <= idx_r + 3'h1;
                  end
               end
            end
         endcase
      end
   end

   // Frame contents captured with the query.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         addr_r <= mer_pkg::BYTE_RST;
         func_r <= mer_pkg::BYTE_RST;
         cause_r <= mer_pkg::BYTE_RST;
         crc_r <= mer_pkg::WORD_RST;
         o_exc_code <= mer_pkg::BYTE_RST;
      end else if (take && !i_qry_bcast && any_err) begin
         addr_r <= i_qry_addr;
         func_r <= i_qry_func | mer_pkg::EXC_FN_FLAG;
         cause_r <= cause_nxt;
         crc_r <= crc_nxt;
         o_exc_code <= cause_nxt;
      end
   end

   // Byte selection in frame order, CRC low byte before high byte.
   always_comb begin
      push = (state_r == mer_pkg::ST_SEND) && buf_in_ready;
      push_last = 1'b0;
      unique case (idx_r)
         mer_pkg::IDX_ADDR: push_data = DATA_W'(addr_r);
         mer_pkg::IDX_FUNC: push_data = DATA_W'(func_r);
         mer_pkg::IDX_CAUSE: push_data = DATA_W'(cause_r);
         mer_pkg::IDX_CRC_LO: push_data = DATA_W'(crc_r[7:0]);
         default: begin
            push_data = DATA_W'(crc_r[15:8]);
            push_last = 1'b1;
         end
      endcase
   end

   // Two-entry skid buffer; the spare slot catches the word in flight on a stall.
   assign buf_in_ready = !spare_valid_r;
   assign pop = o_tx_valid && i_tx_ready;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_tx_valid <= 1'b0;
         o_tx_data <= '0;
         o_tx_last <= 1'b0;
         spare_valid_r <= 1'b0;
         spare_data_r <= '0;
         spare_last_r <= 1'b0;
      end else if (spare_valid_r) begin
         if (pop) begin
            o_tx_data <= spare_data_r;
            o_tx_last <= spare_last_r;
            spare_valid_r <= 1'b0;
         end
      end else if (push) begin
         if (!o_tx_valid || pop) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= push_data;
            o_tx_last <= push_last;
         end else begin
            spare_valid_r <= 1'b1;
            spare_data_r <= push_data;
            spare_last_r <= push_last;
         end
      end else if (pop) begin
         o_tx_valid <= 1'b0;
      end
   end

   // Checks kept next to the logic they guard.
   AST_BCAST_SILENT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && i_qry_bcast |=> !o_normal_req && state_r == mer_pkg::ST_IDLE)
      else $error("broadcast query produced a reply");

   AST_NORMAL_REQ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && !any_err |=> o_normal_req && $stable(o_exc_code))
      else $error("clean query did not request a normal reply");

   AST_EXC_START: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && any_err |=> state_r == mer_pkg::ST_SEND && !o_normal_req
      ##1 o_tx_valid)
      else $error("erroneous query did not start an exception frame");

   AST_ADDR_FIRST: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      push && idx_r == mer_pkg::IDX_ADDR && !o_tx_valid |=> o_tx_data == DATA_W'(addr_r))
      else $error("exception frame does not open with the address");

   AST_FUNC_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && any_err |=> func_r == ($past(i_qry_func) | 8'h80))
      else $error("exception function code lacks the top bit");

   AST_UNSUPPORTED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && !supported |=> o_exc_code == 8'h01)
      else $error("unsupported function not reported as 01h");

   AST_NO_ADDR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && supported && i_chk_no_addr |=> o_exc_code == 8'h02)
      else $error("missing address not reported as 02h");

   AST_OVER_COUNT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && i_qry_func == 8'h03 && !i_chk_no_addr && i_qry_rd_cnt > 16'h0010
      |=> o_exc_code == 8'h03)
      else $error("oversize read not reported as 03h");

   AST_NV_BUSY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && i_qry_func == 8'h06 && i_nv_busy && !i_chk_no_addr &&
      !i_chk_bad_format && !i_chk_upper_word && !i_chk_read_only |=> o_exc_code == 8'h26)
      else $error("write during storage busy not reported as 26h");

   AST_CRC_LOW_FIRST: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      push && idx_r == mer_pkg::IDX_CRC_LO |=> state_r == mer_pkg::ST_SEND &&
      idx_r == mer_pkg::IDX_CRC_HI && push_data == DATA_W'(crc_r[15:8]) && push_last)
      else $error("CRC bytes out of order");

   AST_STALL_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
      else $error("output word changed while stalled");

   // Five pushes need at least five cycles; a stall may only make the frame longer.
   AST_FRAME_LEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(state_r == mer_pkg::ST_SEND) |-> (state_r == mer_pkg::ST_SEND) [*5])
      else $error("exception frame ended before five bytes");

   AST_BAD_FORMAT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && supported && !i_chk_no_addr && i_chk_bad_format
      |=> o_exc_code == 8'h03)
      else $error("bad data format not reported as 03h");

   AST_UPPER_WORD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take && !i_qry_bcast && supported && !i_chk_no_addr && !i_chk_bad_format && !cnt_err &&
      i_chk_upper_word |=> o_exc_code == 8'h27)
      else $error("upper word access not reported as 27h");

   AST_SEND_REFUSES: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_r == mer_pkg::ST_SEND |-> !o_qry_ready)
      else $error("query accepted while an exception frame is queued");

endmodule

/* File: logic/mer_pkg.sv */
package mer_pkg;

   // Function codes that the drive answers.
   localparam logic [7:0] FN_READ_COILS = 8'h01;
   localparam logic [7:0] FN_READ_REGS = 8'h03;
   localparam logic [7:0] FN_WRITE_COIL = 8'h05;
   localparam logic [7:0] FN_WRITE_REG = 8'h06;
   localparam logic [7:0] FN_WRITE_COILS = 8'h0f;
   localparam logic [7:0] FN_WRITE_REGS = 8'h10;
   localparam logic [7:0] FN_RW_REGS = 8'h17;

   // Added to the query's function code in an exception reply.
   localparam logic [7:0] EXC_FN_FLAG = 8'h80;

   // Cause codes carried in the third byte of an exception reply.
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_BAD_FORMAT = 8'h03;
   localparam logic [7:0] EXC_OUT_OF_RANGE = 8'h21;
   localparam logic [7:0] EXC_REFUSED = 8'h22;
   localparam logic [7:0] EXC_READ_ONLY = 8'h23;
   localparam logic [7:0] EXC_NV_BUSY = 8'h26;
   localparam logic [7:0] EXC_UPPER_WORD = 8'h27;
   localparam logic [7:0] EXC_MAP_ERR1 = 8'h31;
   localparam logic [7:0] EXC_MAP_ERR2 = 8'h32;

   // Largest register count in one multi-register request.
   localparam logic [15:0] MAX_REGS = 16'h0010;

   // CRC-16 settings, reflected form of the usual polynomial.
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;

   // Exception frame layout: byte index of each field.
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_FUNC = 3'h1;
   localparam logic [2:0] IDX_CAUSE = 3'h2;
   localparam logic [2:0] IDX_CRC_LO = 3'h3;
   localparam logic [2:0] IDX_CRC_HI = 3'h4;

   // Reset values.
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;

   // Controller states, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } mer_state_t;

endpackage

/* File: verif/mer_tx_sink.sv */
`timescale 1ns/1ps
// Transmitter model: takes exception bytes and can stall two cycles in three.
module mer_tx_sink (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Byte stream from the responder.
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   output logic o_tx_ready,
   // Bench control and status.
   input wire logic i_stall,
   output int o_cnt,
   output logic o_hold_err
);
   logic [7:0] byte_q [0:63];
   logic last_q [0:63];
   logic [1:0] cyc_r;
   logic wait_r;
   logic [7:0] held_r;

   // A slow transmitter is what shows whether the buffer drops or alters a byte.
   assign o_tx_ready = !i_stall || (cyc_r == 2'h0);

   // Store accepted bytes; a refused byte must stand unchanged until taken.
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         cyc_r <= 2'h0;
         o_cnt <= 0;
         wait_r <= 1'b0;
         o_hold_err <= 1'b0;
      end else begin
         cyc_r <= (cyc_r == 2'h2) ? 2'h0 : cyc_r + 2'h1;
         if (wait_r && i_tx_data !== held_r) begin
            o_hold_err <= 1'b1;
         end
         wait_r <= i_tx_valid && !o_tx_ready;
         held_r <= i_tx_data;
         if (i_tx_valid && o_tx_ready) begin
            byte_q[o_cnt % 64] <= i_tx_data;
            last_q[o_cnt % 64] <= i_tx_last;
            o_cnt <= o_cnt + 1;
         end
      end
   end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the exception responder.
module testbench;
   logic i_clk;
   logic i_sys_rst;
   logic qv;
   logic o_qry_ready;
   logic [7:0] qa;
   logic [7:0] qf;
   logic qb;
   logic [15:0] qrd;
   logic [15:0] qwr;
   logic [7:0] qbn;
   logic [13:0] ck_r;
   logic o_normal_req;
   logic [7:0] o_exc_code;
   logic o_tx_valid;
   logic tx_ready;
   logic [7:0] o_tx_data;
   logic o_tx_last;
   logic stall;
   logic hold_err;
   int sink_cnt;
   int err_total;
   int checks;
   int cyc;

   // Check flags are packed so that each scenario names a cause by one bit.
   mer_exception_responder #(.DATA_W(8)) dut_u (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_qry_valid(qv), .o_qry_ready(o_qry_ready),
      .i_qry_addr(qa), .i_qry_func(qf), .i_qry_bcast(qb), .i_qry_rd_cnt(qrd),
      .i_qry_wr_cnt(qwr), .i_qry_byte_cnt(qbn), .i_chk_no_addr(ck_r[0]),
      .i_chk_bad_format(ck_r[1]), .i_chk_out_of_range(ck_r[2]), .i_chk_run_locked(ck_r[3]),
      .i_chk_soft_locked(ck_r[4]), .i_chk_fixed_pin(ck_r[5]),
      .i_chk_reset_terminal_function(ck_r[6]), .i_chk_pw_locked(ck_r[7]),
      .i_chk_read_only(ck_r[8]), .i_chk_upper_word(ck_r[9]), .i_chk_map_err1(ck_r[10]),
      .i_chk_map_err2(ck_r[11]), .i_autotune_on(ck_r[12]), .i_nv_busy(ck_r[13]),
      .o_normal_req(o_normal_req), .o_exc_code(o_exc_code), .o_tx_valid(o_tx_valid),
      .i_tx_ready(tx_ready), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last));

   mer_tx_sink sink_u (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
      .i_tx_last(o_tx_last), .o_tx_ready(tx_ready), .i_stall(stall), .o_cnt(sink_cnt),
      .o_hold_err(hold_err));

   // Free-running clock, 10 ns period.
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Hang guard; the whole run needs a few hundred cycles.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Reflected CRC over the three leading bytes of an exception frame.
   function automatic logic [15:0] crc16(input logic [7:0] a, b, c);
      logic [15:0] r;
      logic [23:0] d;
      r = mer_pkg::CRC_INIT;
      d = {c, b, a};
      for (int i = 0; i < 3; i++) begin
         r = r ^ {8'h00, d[8*i +: 8]};
         for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ mer_pkg::CRC_POLY) : (r >> 1);
         end
      end
      return r;
   endfunction

   // Offer one query, then judge the normal pulse and any exception frame.
   // A cause of zero means no frame is expected.
   task automatic run_q(input logic [7:0] fn, input logic bc, input logic [15:0] rd,
         input logic [15:0] wr, input logic [7:0] bn, input logic [13:0] ck,
         input logic [7:0] cs);
      int base;
      int n;
      logic [7:0] f [0:4];
      logic [15:0] crc;
      base = sink_cnt;
      f[0] = 8'h20 + fn;
      f[1] = fn + mer_pkg::EXC_FN_FLAG;
      f[2] = cs;
      crc = crc16(f[0], f[1], f[2]);
      f[3] = crc[7:0];
      f[4] = crc[15:8];
      @(posedge i_clk);
      qv <= 1'b1;
      qa <= f[0];
      qf <= fn;
      qb <= bc;
      qrd <= rd;
      qwr <= wr;
      qbn <= bn;
      ck_r <= ck;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_qry_ready !== 1'b1 && n < 50);
      @(posedge i_clk);
      qv <= 1'b0;
      @(negedge i_clk);
      check({7'h00, o_normal_req}, {7'h00, !bc && cs == 8'h00});
      if (cs == 8'h00 || bc) begin
         repeat (8) @(negedge i_clk);
         check(8'(sink_cnt - base), 8'h00);
      end else begin
         for (n = 0; n < 60 && sink_cnt != base + 5; n++) @(negedge i_clk);
         check(o_exc_code, cs);
         for (n = 0; n < 5; n++) begin
            check(sink_u.byte_q[(base + n) % 64], f[n]);
            check({7'h00, sink_u.last_q[(base + n) % 64]}, {7'h00, n == 4});
         end
      end
   endtask

   task automatic t_reset();
      check({4'h0, o_normal_req, o_tx_last, o_tx_valid, o_qry_ready}, 8'h00);
      check(o_exc_code, 8'h00);
   endtask

   // Clean queries, including a full 16-register write and a read of a read-only register.
   task automatic t_clean();
      run_q(8'h03, 1'b0, 16'h0002, 16'h0000, 8'h00, 14'h0000, 8'h00);
      run_q(8'h10, 1'b0, 16'h0000, 16'h0010, 8'h20, 14'h0000, 8'h00);
      run_q(8'h03, 1'b0, 16'h0001, 16'h0000, 8'h00, 14'h0100, 8'h00);
   endtask

   // Broadcasts are silent, erroneous or not.
   task automatic t_bcast();
      run_q(8'h02, 1'b1, 16'h0000, 16'h0000, 8'h00, 14'h0000, 8'h01);
      run_q(8'h06, 1'b1, 16'h0000, 16'h0000, 8'h00, 14'h0000, 8'h00);
   endtask

   // Every supported function, with a missing target, gets its flagged code.
   task automatic t_funcs();
      logic [7:0] fl [0:6];
      fl = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h17};
      for (int i = 0; i < 7; i++) begin
         run_q(fl[i], 1'b0, 16'h0001, 16'h0001, 8'h02, 14'h0001, 8'h02);
      end
   endtask

   task automatic t_unsup();
      run_q(8'h02, 1'b0, 16'h0001, 16'h0000, 8'h00, 14'h0000, 8'h01);
      run_q(8'h2b, 1'b0, 16'h0001, 16'h0000, 8'h00, 14'h0000, 8'h01);
   endtask

   // One check flag at a time on a single-register write.
   task automatic t_causes();
      logic [7:0] cl [0:13];
      logic [13:0] ckv;
      cl = '{8'h02, 8'h03, 8'h21, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h23, 8'h27,
             8'h31, 8'h32, 8'h22, 8'h26};
      for (int i = 1; i < 14; i++) begin
         ckv = 14'h0001 << i;
         run_q(8'h06, 1'b0, 16'h0, 16'h0, 8'h0, ckv, cl[i]);
      end
   endtask

   // Count limits: 17 registers, zero registers and a byte count mismatch.
   task automatic t_count();
      run_q(8'h10, 1'b0, 16'h0000, 16'h0011, 8'h22, 14'h0000, 8'h03);
      run_q(8'h10, 1'b0, 16'h0000, 16'h0002, 8'h03, 14'h0000, 8'h03);
      run_q(8'h03, 1'b0, 16'h0000, 16'h0000, 8'h00, 14'h0000, 8'h03);
      run_q(8'h17, 1'b0, 16'h0011, 16'h0001, 8'h02, 14'h0000, 8'h03);
   endtask

   // Frames through a stalling transmitter lose and alter nothing.
   task automatic t_stall();
      @(posedge i_clk);
      stall <= 1'b1;
      run_q(8'h0f, 1'b0, 16'h0, 16'h0, 8'h0, 14'h0100, 8'h23);
      run_q(8'h17, 1'b0, 16'h1, 16'h1, 8'h2, 14'h1000, 8'h22);
      @(posedge i_clk);
      stall <= 1'b0;
      @(negedge i_clk);
      check({7'h00, hold_err}, 8'h00);
   endtask

   // Main sequence: inputs settle at time zero, reset holds eleven cycles.
   initial begin
      i_sys_rst = 1'b1;
      qv = 1'b0;
      qa = 8'h00;
      qf = 8'h00;
      qb = 1'b0;
      qrd = 16'h0000;
      qwr = 16'h0000;
      qbn = 8'h00;
      ck_r = 14'h0000;
      stall = 1'b0;
      err_total = 0;
      checks = 0;
      cyc = 0;
      repeat (10) @(posedge i_clk);
      @(negedge i_clk);
      t_reset();
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_clean();
      t_bcast();
      t_funcs();
      t_unsup();
      t_causes();
      t_count();
      t_stall();
      tally_and_finish();
   end
endmodule
